// ==== common/iop_defines.svh ====
// Constants for the I/O port block: addresses, widths, reset values
//
// Notes on behaviour
// - Wide, input-only and narrow ports sit at addresses 12h, 14h, 16h.
// - Input-only port is read only; writes never reach its pins.
// - Reads are not latched; pins are sampled at the phase-two edge.
// - Bidirectional port outputs hold their latch until rewritten.
// - After reset input lines sit high or float, by pull-up option.
// - Each latch bit at 12h and 16h can be singly set or cleared.
// - Set, clear, complement read whole port, modify, write back.
// - Wide port high nibble open-drain pulled up; low nibble selectable.
// - Narrow port is push-pull output or open-drain I/O, pull-up option.
// - Push-pull nibbles are output only; open-drain nibbles are I/O.
// - Open-drain input bits of the wide port may be wake-up sources.
// - Wake-up bits wake from halt on a falling edge; other ports never.
// - Buzzer option replaces wide port bits zero and one with buzzer pair.
// - Clearing latch bits zero and one starts buzzer; setting bit zero stops.
// - Buzzer frequency is clock divided by four up to 512, eight choices.
`ifndef IOP_DEFINES_SVH
`define IOP_DEFINES_SVH

// ---------------------------------------------------------------
// Address map
// ---------------------------------------------------------------
`define IOP_ADDR_W 8
`define IOP_ADDR_WIDE 8'h12
`define IOP_ADDR_INPUT 8'h14
`define IOP_ADDR_NARROW 8'h16

// ---------------------------------------------------------------
// Widths and fields
// ---------------------------------------------------------------
`define IOP_DATA_W 8
`define IOP_NIB 4
`define IOP_BIT_SEL_W 3
`define IOP_BZ_BIT 0
`define IOP_BZN_BIT 1
`define IOP_BIT_ONE 8'h01
`define IOP_ZERO 8'h00
`define IOP_NIB_ZERO 4'h0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define IOP_LATCH_RST 8'hff
`define IOP_NARROW_RST 4'hf

// ---------------------------------------------------------------
// Buzzer divider: period is 2^(sel+2) clocks
// ---------------------------------------------------------------
`define IOP_BZ_SEL_W 3
`define IOP_BZ_CNT_W 9
`define IOP_BZ_IDX_W 4
`define IOP_BZ_IDX_OFS 4'h1
`define IOP_BZ_CNT_ONE 9'h001
`define IOP_BZ_CNT_RST 9'h000

`endif

// ==== common/iop_pkg.sv ====
// Types shared by the I/O port block
package iop_pkg;

  // ---------------------------------------------------------------
  // Data-memory operations issued by the CPU core
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    IOP_OP_READ,
    IOP_OP_WRITE,
    IOP_OP_SET,
    IOP_OP_CLR,
    IOP_OP_CPL,
    IOP_OP_CPLA
  } iop_op_t;

endpackage

// ==== hw/iop_bzdiv.sv ====
// Buzzer tone divider: square wave of 2^(sel+2) clock periods
`timescale 1ns/1ps
`default_nettype none
`include "iop_defines.svh"

module iop_bzdiv (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic run_in,
  input wire logic [`IOP_BZ_SEL_W-1:0] sel_in,
  output logic tone_out
);

  logic [`IOP_BZ_CNT_W-1:0] cnt_q;
  logic [`IOP_BZ_IDX_W-1:0] idx;
  logic tone_q;

  // Tap one counter bit above the selector so div-4 is the fastest
  assign idx = {1'b0, sel_in} + `IOP_BZ_IDX_OFS;

  // ---------------------------------------------------------------
  // Counter, held in reset while stopped so each burst starts alike
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!resetn_in || !run_in) begin
      cnt_q <= `IOP_BZ_CNT_RST;
    end else begin
      cnt_q <= cnt_q + `IOP_BZ_CNT_ONE;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in || !run_in) begin
      tone_q <= 1'b0;
    end else begin
      tone_q <= cnt_q[idx];
    end
  end

  assign tone_out = tone_q;

endmodule // iop_bzdiv

`default_nettype wire

// ==== hw/iop_ports.sv ====
// Wide, input-only and narrow I/O ports with wake-up and buzzer pair
`timescale 1ns/1ps
`default_nettype none
`include "iop_defines.svh"

module iop_ports
  import iop_pkg::*;
#(
  // Mask-style options, fixed when the chip is built
  parameter logic PA_LO_PUSHPULL = 1'b0,
  parameter logic PA_LO_PULLUP = 1'b1,
  parameter logic PC_PUSHPULL = 1'b0,
  parameter logic PC_PULLUP = 1'b1,
  parameter logic [7:0] PB_PULLUP = 8'hff,
  parameter logic [7:0] PA_WAKE_EN = 8'h00,
  parameter logic BUZZER_EN = 1'b0,
  parameter logic [2:0] BUZZER_DIV_SEL = 3'h0
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  // CPU data-memory access
  input wire logic req_in,
  input wire logic phase_two_in,
  input wire iop_op_t op_in,
  input wire logic [`IOP_ADDR_W-1:0] addr_in,
  input wire logic [`IOP_BIT_SEL_W-1:0] bit_sel_in,
  input wire logic [`IOP_DATA_W-1:0] wdata_in,
  output logic [`IOP_DATA_W-1:0] rdata_out,
  output logic hit_out,
  output logic done_out,
  // Wide bidirectional port
  input wire logic [`IOP_DATA_W-1:0] wide_bidir_port_in,
  output logic [`IOP_DATA_W-1:0] wide_bidir_port_out,
  output logic [`IOP_DATA_W-1:0] wide_bidir_port_oe_out,
  output logic [`IOP_DATA_W-1:0] wide_pullup_out,
  // Input-only port
  input wire logic [`IOP_DATA_W-1:0] input_only_port_in,
  output logic [`IOP_DATA_W-1:0] input_only_pullup_out,
  // Narrow bidirectional port
  input wire logic [`IOP_NIB-1:0] narrow_bidir_port_in,
  output logic [`IOP_NIB-1:0] narrow_bidir_port_out,
  output logic [`IOP_NIB-1:0] narrow_bidir_port_oe_out,
  output logic [`IOP_NIB-1:0] narrow_pullup_out,
  // Halt wake-up and buzzer status
  output logic wake_out,
  output logic buzzer_active_out
);

  // ---------------------------------------------------------------
  // Static structure masks
  // ---------------------------------------------------------------
  // High nibble of the wide port has no push-pull choice
  localparam logic [`IOP_DATA_W-1:0] PA_OD =
    {{`IOP_NIB{1'b1}}, {`IOP_NIB{~PA_LO_PUSHPULL}}};
  localparam logic [`IOP_DATA_W-1:0] PA_PU =
    {{`IOP_NIB{1'b1}}, {`IOP_NIB{PA_LO_PULLUP}}};
  localparam logic [`IOP_NIB-1:0] PC_OD = {`IOP_NIB{~PC_PUSHPULL}};
  localparam logic [`IOP_NIB-1:0] PC_PU = {`IOP_NIB{PC_PULLUP}};
  // Buzzer pair takes over the two lowest wide-port pins
  localparam logic [`IOP_DATA_W-1:0] BZ_MASK =
    BUZZER_EN ? ((`IOP_BIT_ONE << `IOP_BZ_BIT) |
                 (`IOP_BIT_ONE << `IOP_BZN_BIT)) : `IOP_ZERO;
  // Wake-up only on open-drain input pins that are not buzzer pins
  localparam logic [`IOP_DATA_W-1:0] WAKE_MASK =
    PA_WAKE_EN & PA_OD & ~BZ_MASK;
  // Buzzer pins read back their latch, never the tone on the pad
  localparam logic [`IOP_DATA_W-1:0] PA_SENSE = PA_OD & ~BZ_MASK;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // Open-drain bits read the pad, output-only bits read their latch
  function automatic logic [`IOP_DATA_W-1:0] sense(
    input logic [`IOP_DATA_W-1:0] pins,
    input logic [`IOP_DATA_W-1:0] latch,
    input logic [`IOP_DATA_W-1:0] od
  );
    sense = (pins & od) | (latch & ~od);
  endfunction

  function automatic logic is_wide(input logic [`IOP_ADDR_W-1:0] a);
    is_wide = (a == `IOP_ADDR_WIDE);
  endfunction

  function automatic logic is_input(input logic [`IOP_ADDR_W-1:0] a);
    is_input = (a == `IOP_ADDR_INPUT);
  endfunction

  function automatic logic is_narrow(input logic [`IOP_ADDR_W-1:0] a);
    is_narrow = (a == `IOP_ADDR_NARROW);
  endfunction

  function automatic logic is_latched(input logic [`IOP_ADDR_W-1:0] a);
    is_latched = is_wide(a) || is_narrow(a);
  endfunction

  function automatic logic is_mapped(input logic [`IOP_ADDR_W-1:0] a);
    is_mapped = is_latched(a) || is_input(a);
  endfunction

  // CPLA leaves the latch alone and only returns the value
  function automatic logic op_writes(input iop_op_t op);
    op_writes = (op == IOP_OP_WRITE) || (op == IOP_OP_SET) ||
                (op == IOP_OP_CLR) || (op == IOP_OP_CPL);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [`IOP_DATA_W-1:0] wide_latch_q;
  logic [`IOP_NIB-1:0] narrow_latch_q;
  logic [`IOP_DATA_W-1:0] rdata_q;
  logic hit_q;
  logic done_q;
  logic [`IOP_DATA_W-1:0] wide_prev_q;
  logic wake_q;
  logic [`IOP_DATA_W-1:0] wide_fell;
  logic bz_run_q;
  logic bz_start;
  logic bz_stop;
  logic tone;

  // ---------------------------------------------------------------
  // Access decode and read-modify-write datapath
  // ---------------------------------------------------------------
  logic taken;
  logic mapped;
  logic [`IOP_DATA_W-1:0] wide_sense;
  logic [`IOP_DATA_W-1:0] narrow_sense;
  logic [`IOP_DATA_W-1:0] port_val;
  logic [`IOP_DATA_W-1:0] bit_mask;
  logic [`IOP_DATA_W-1:0] result;
  logic writes_latch;
  logic wide_wr;
  logic narrow_wr;

  // The core pulses phase_two_in once per instruction; that edge is
  // where the pads are looked at, with no holding register in front
  assign taken = req_in && phase_two_in;
  assign mapped = is_mapped(addr_in);

  assign wide_sense = sense(wide_bidir_port_in, wide_latch_q,
                            PA_SENSE);
  assign narrow_sense = sense({`IOP_NIB_ZERO, narrow_bidir_port_in},
                              {`IOP_NIB_ZERO, narrow_latch_q},
                              {`IOP_NIB_ZERO, PC_OD});

  always_comb begin
    unique case (addr_in)
      `IOP_ADDR_WIDE: port_val = wide_sense;
      `IOP_ADDR_INPUT: port_val = input_only_port_in;
      `IOP_ADDR_NARROW: port_val = narrow_sense;
      default: port_val = `IOP_ZERO;
    endcase
  end

  assign bit_mask = `IOP_BIT_ONE << bit_sel_in;

  // Bit operations start from the whole port state, not the latch
  always_comb begin
    unique case (op_in)
      IOP_OP_READ: result = port_val;
      IOP_OP_WRITE: result = wdata_in;
      IOP_OP_SET: result = port_val | bit_mask;
      IOP_OP_CLR: result = port_val & ~bit_mask;
      IOP_OP_CPL: result = ~port_val;
      IOP_OP_CPLA: result = ~port_val;
      default: result = `IOP_ZERO;
    endcase
  end

  assign writes_latch = op_writes(op_in);
  // The input-only address never reaches a latch
  assign wide_wr = taken && writes_latch && is_wide(addr_in);
  assign narrow_wr = taken && writes_latch && is_narrow(addr_in);

  // ---------------------------------------------------------------
  // Output latches
  // ---------------------------------------------------------------
  // Reset to ones so open-drain pins release: pull-up or float
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      wide_latch_q <= `IOP_LATCH_RST;
    end else if (wide_wr) begin
      wide_latch_q <= result;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      narrow_latch_q <= `IOP_NARROW_RST;
    end else if (narrow_wr) begin
      narrow_latch_q <= result[`IOP_NIB-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Read answer to the core
  // ---------------------------------------------------------------
  // The answer is the value that the operation produced; writes echo
  // what went into the latch, unmapped addresses answer zero
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      rdata_q <= `IOP_ZERO;
    end else if (taken) begin
      if (!mapped) begin
        rdata_q <= `IOP_ZERO;
      end else if (is_narrow(addr_in)) begin
        rdata_q <= {`IOP_NIB_ZERO, result[`IOP_NIB-1:0]};
      end else begin
        rdata_q <= result;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      hit_q <= 1'b0;
    end else if (taken) begin
      // A miss changes no latch; only hit_out tells the core
      hit_q <= mapped;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      done_q <= 1'b0;
    end else begin
      // One-cycle pulse in the cycle after the phase-two edge
      done_q <= taken;
    end
  end

  assign rdata_out = rdata_q;
  assign hit_out = hit_q;
  assign done_out = done_q;

  // ---------------------------------------------------------------
  // Wide port pin drivers
  // ---------------------------------------------------------------
  // Open-drain: pull low only while the latch holds zero. Push-pull:
  // always drive, so such a pin can never be used as an input
  for (genvar i = 0; i < `IOP_DATA_W; i++) begin : g_wide
    if (BZ_MASK[i]) begin : g_bz
      // Both buzzer pins rest low while stopped
      if (i == `IOP_BZ_BIT) begin : g_pos
        assign wide_bidir_port_out[i] = bz_run_q && tone;
      end else begin : g_neg
        assign wide_bidir_port_out[i] = bz_run_q && !tone;
      end
      assign wide_bidir_port_oe_out[i] = 1'b1;
    end else if (PA_OD[i]) begin : g_od
      assign wide_bidir_port_out[i] = 1'b0;
      assign wide_bidir_port_oe_out[i] = !wide_latch_q[i];
    end else begin : g_pp
      assign wide_bidir_port_out[i] = wide_latch_q[i];
      assign wide_bidir_port_oe_out[i] = 1'b1;
    end
  end

  assign wide_pullup_out = PA_PU;

  // ---------------------------------------------------------------
  // Narrow port pin drivers
  // ---------------------------------------------------------------
  for (genvar j = 0; j < `IOP_NIB; j++) begin : g_narrow
    if (PC_OD[j]) begin : g_od
      assign narrow_bidir_port_out[j] = 1'b0;
      assign narrow_bidir_port_oe_out[j] = !narrow_latch_q[j];
    end else begin : g_pp
      assign narrow_bidir_port_out[j] = narrow_latch_q[j];
      assign narrow_bidir_port_oe_out[j] = 1'b1;
    end
  end

  assign narrow_pullup_out = PC_PU;

  // ---------------------------------------------------------------
  // Input-only port
  // ---------------------------------------------------------------
  // No driver exists for these pins at all; only pull-ups
  assign input_only_pullup_out = PB_PULLUP;

  // ---------------------------------------------------------------
  // Halt wake-up
  // ---------------------------------------------------------------
  // Previous level resets high so a pin held low at reset release is
  // taken as a falling edge; a pad low out of reset should wake anyway
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      wide_prev_q <= `IOP_LATCH_RST;
    end else begin
      wide_prev_q <= wide_bidir_port_in;
    end
  end

  // Only the wide port feeds this; the other ports never wake
  assign wide_fell = wide_prev_q & ~wide_bidir_port_in & WAKE_MASK;

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= |wide_fell;
    end
  end

  assign wake_out = wake_q;

  // ---------------------------------------------------------------
  // Buzzer control
  // ---------------------------------------------------------------
  // Start needs both low bits cleared together; setting bit zero stops.
  // Setting bit one alone leaves a running buzzer running
  assign bz_stop = BUZZER_EN && wide_wr && result[`IOP_BZ_BIT];
  assign bz_start = BUZZER_EN && wide_wr && !result[`IOP_BZ_BIT] &&
                    !result[`IOP_BZN_BIT];

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      bz_run_q <= 1'b0;
    end else if (bz_stop) begin
      bz_run_q <= 1'b0;
    end else if (bz_start) begin
      bz_run_q <= 1'b1;
    end
  end

  assign buzzer_active_out = bz_run_q;

  // Divisor is a build option, not software-visible
  iop_bzdiv u_bzdiv (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .run_in(bz_run_q),
    .sel_in(BUZZER_DIV_SEL),
    .tone_out(tone)
  );

endmodule // iop_ports

`default_nettype wire

// ==== test/iop_ports_checker.sv ====
// Concurrent checks on the I/O port block, bound into its top module
`timescale 1ns/1ps
`default_nettype none
`include "iop_defines.svh"
module iop_ports_checker
  import iop_pkg::*;
#(
  parameter logic PA_LO_PUSHPULL = 1'b0,
  parameter logic [7:0] PA_WAKE_EN = 8'h00,
  parameter logic BUZZER_EN = 1'b0
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic req_in,
  input wire logic phase_two_in,
  input wire iop_op_t op_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rdata_out,
  input wire logic hit_out,
  input wire logic done_out,
  input wire logic [7:0] wide_bidir_port_in,
  input wire logic [7:0] wide_bidir_port_out,
  input wire logic [7:0] wide_bidir_port_oe_out,
  input wire logic wake_out,
  input wire logic buzzer_active_out
);
  // ---------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------
  logic [7:0] prev_q;
  logic [7:0] wmask;
  logic take;
  logic fell;
  logic mapped;
  logic wr_wide;
  assign take = req_in & phase_two_in;
  assign mapped = addr_in inside {`IOP_ADDR_WIDE, `IOP_ADDR_INPUT,
    `IOP_ADDR_NARROW};
  assign wr_wide = take && op_in == IOP_OP_WRITE && addr_in == `IOP_ADDR_WIDE;
  // Only open-drain pins that are not lent to the buzzer can wake
  assign wmask = PA_WAKE_EN & {4'hf, {2{~PA_LO_PUSHPULL}},
    {2{~PA_LO_PUSHPULL & ~BUZZER_EN}}};
  assign fell = |(prev_q & ~wide_bidir_port_in & wmask);
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      prev_q <= `IOP_LATCH_RST;
    end else begin
      prev_q <= wide_bidir_port_in;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  a_done_after_take: assert property (take |=> done_out)
    else $error("no completion after a request");
  a_unmapped_quiet: assert property (take && !mapped |=>
    !hit_out && rdata_out == `IOP_ZERO) else $error("unmapped access hit");
  a_wake_on_fall: assert property (fell |=> wake_out)
    else $error("falling wake pin gave no wake");
  a_wake_has_cause: assert property (wake_out |-> $past(fell))
    else $error("wake without an enabled falling pin");
  a_latch_holds: assert property (!take |=>
    $stable(wide_bidir_port_oe_out)) else $error("latch moved on its own");
  a_buzzer_pair: assert property (BUZZER_EN && buzzer_active_out |->
    wide_bidir_port_out[1] != wide_bidir_port_out[0])
    else $error("buzzer pair not complementary");
  a_buzz_start: assert property (BUZZER_EN && wr_wide &&
    wdata_in[1:0] == 2'b00 |=> buzzer_active_out) else $error("no start");
  a_buzz_stop: assert property (BUZZER_EN && wr_wide &&
    wdata_in[0] |=> !buzzer_active_out) else $error("buzzer did not stop");
  c_cpla: cover property (take && op_in == IOP_OP_CPLA);
  c_wake: cover property (wake_out);
  c_buzz: cover property ($rose(buzzer_active_out));
endmodule // iop_ports_checker
bind iop_ports iop_ports_checker #(.PA_LO_PUSHPULL(PA_LO_PUSHPULL),
  .PA_WAKE_EN(PA_WAKE_EN), .BUZZER_EN(BUZZER_EN)) iop_ports_checker_inst (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .req_in(req_in),
  .phase_two_in(phase_two_in), .op_in(op_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .rdata_out(rdata_out), .hit_out(hit_out),
  .done_out(done_out), .wide_bidir_port_in(wide_bidir_port_in),
  .wide_bidir_port_out(wide_bidir_port_out), .wake_out(wake_out),
  .wide_bidir_port_oe_out(wide_bidir_port_oe_out),
  .buzzer_active_out(buzzer_active_out));
`default_nettype wire

// ==== test/iop_pins_model.sv ====
// Board-side pin model: pull-ups, external drivers and floating lines
`timescale 1ns/1ps
`default_nettype none
module iop_pins_model #(
  parameter int W = 8
) (
  input wire logic mclk_in,
  input wire logic [W-1:0] oe_in,
  input wire logic [W-1:0] drive_in,
  input wire logic [W-1:0] pullup_in,
  input wire logic [W-1:0] ext_en_in,
  input wire logic [W-1:0] ext_val_in,
  output logic [W-1:0] pin_out
);
  // Unpulled idle lines wander so a stale level never reads back
  logic [W-1:0] float_q = '0;
  always @(posedge mclk_in) float_q <= ~float_q;
  assign pin_out = (oe_in & drive_in) | (~oe_in & ((ext_en_in & ext_val_in) |
    (~ext_en_in & (pullup_in | float_q))));
endmodule // iop_pins_model
`default_nettype wire

// ==== test/test_io_ports_with_buzzer.sv ====
// Self-checking bench for the three I/O ports, wake-up and buzzer pair
`timescale 1ns/1ps
`default_nettype none
`include "iop_defines.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  miscompares++; $display("BAD %0t got %h want %h", $time, got, exp); end end
module test_io_ports_with_buzzer
  import iop_pkg::*;
;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic req_in = 1'b0;
  logic phase_two_in = 1'b0;
  iop_op_t op_in = IOP_OP_READ;
  logic [2:0] bit_sel_in = 3'h0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  // Build options of the device under test
  localparam logic [7:0] P_WAKE = 8'h24;
  localparam logic [7:0] P_PB_PU = 8'h0f;
  localparam logic P_BZ_ON = 1'b1;
  localparam logic [2:0] P_BZ_SEL = 3'h1;
  localparam logic P_PC_PP = 1'b1;
  localparam logic P_PC_PU = 1'b0;
  logic [7:0] wx_en = 8'h00;
  logic [7:0] pb_val = 8'h5a;
  logic [7:0] pb_xen = 8'hff;
  logic [3:0] pc_xen = 4'h0;
  logic [3:0] pc_xval = 4'h0;
  logic [7:0] rdata_out, wide_in, wide_out, wide_oe, wide_pu, pb_in, pb_pu;
  logic [3:0] pc_in, pc_out, pc_oe, pc_pu;
  logic hit_out, done_out, wake_out, buzzer_active_out;
  logic [7:0] res;
  int miscompares = 0;
  int tests_run = 0;
  initial forever #10 mclk_in = ~mclk_in;
  iop_ports #(.PA_WAKE_EN(P_WAKE), .BUZZER_EN(P_BZ_ON),
    .BUZZER_DIV_SEL(P_BZ_SEL), .PC_PUSHPULL(P_PC_PP), .PC_PULLUP(P_PC_PU),
    .PB_PULLUP(P_PB_PU)) iop_ports_inst (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .req_in(req_in),
    .phase_two_in(phase_two_in), .op_in(op_in), .addr_in(addr_in),
    .bit_sel_in(bit_sel_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
    .hit_out(hit_out), .done_out(done_out), .wide_bidir_port_in(wide_in),
    .wide_bidir_port_out(wide_out), .wide_bidir_port_oe_out(wide_oe),
    .wide_pullup_out(wide_pu), .input_only_port_in(pb_in),
    .input_only_pullup_out(pb_pu), .narrow_bidir_port_in(pc_in),
    .narrow_bidir_port_out(pc_out), .narrow_bidir_port_oe_out(pc_oe),
    .narrow_pullup_out(pc_pu), .wake_out(wake_out),
    .buzzer_active_out(buzzer_active_out));
  iop_pins_model wide_pins (.mclk_in(mclk_in), .oe_in(wide_oe),
    .drive_in(wide_out), .pullup_in(wide_pu), .ext_en_in(wx_en),
    .ext_val_in(8'h00), .pin_out(wide_in));
  iop_pins_model pb_pins (.mclk_in(mclk_in), .oe_in(8'h00),
    .drive_in(8'h00), .pullup_in(pb_pu), .ext_en_in(pb_xen),
    .ext_val_in(pb_val), .pin_out(pb_in));
  iop_pins_model #(.W(4)) pc_pins (.mclk_in(mclk_in), .oe_in(pc_oe),
    .drive_in(pc_out), .pullup_in(pc_pu), .ext_en_in(pc_xen),
    .ext_val_in(pc_xval), .pin_out(pc_in));
  // ---------------------------------------------------------------
  // Shared tasks; each is entered and left on a rising edge
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic acc(input iop_op_t op, input logic [7:0] a,
    input logic [2:0] b, input logic [7:0] d);
    req_in <= 1'b1;
    phase_two_in <= 1'b1;
    op_in <= op;
    addr_in <= a;
    bit_sel_in <= b;
    wdata_in <= d;
    @(posedge mclk_in);
    req_in <= 1'b0;
    phase_two_in <= 1'b0;
    @(negedge mclk_in);
    `CHK(done_out, 1'b1)
    res = rdata_out;
    @(posedge mclk_in);
  endtask
  task automatic t_reset();
    `CHK(wide_oe, 8'h03)
    `CHK(wide_out, 8'h00)
    `CHK({pc_out, pc_oe}, 8'hff)
    `CHK({wide_pu, pb_pu, pc_pu}, {8'hff, P_PB_PU, {4{P_PC_PU}}})
    $display("t_reset finished");
  endtask
  task automatic t_read();
    acc(IOP_OP_READ, 8'h14, 3'h0, 8'h00);
    `CHK({hit_out, res}, 9'h15a)
    pb_val <= 8'ha5;
    acc(IOP_OP_READ, 8'h14, 3'h0, 8'h00);
    `CHK(res, 8'ha5)
    pb_xen <= 8'hf0;
    acc(IOP_OP_READ, 8'h14, 3'h0, 8'h00);
    `CHK(res, 8'haf)
    pb_xen <= 8'hff;
    wx_en <= 8'h50;
    acc(IOP_OP_READ, 8'h12, 3'h0, 8'h00);
    `CHK(res, 8'haf)
    wx_en <= 8'h00;
    pc_xen <= 4'hf;
    pc_xval <= 4'h5;
    acc(IOP_OP_READ, 8'h16, 3'h0, 8'h00);
    `CHK(res, 8'h0f)
    acc(IOP_OP_READ, 8'h13, 3'h0, 8'h00);
    `CHK({hit_out, res}, 9'h000)
    $display("t_read finished");
  endtask
  task automatic t_write_bits();
    logic [7:0] e;
    acc(IOP_OP_WRITE, 8'h12, 3'h0, 8'hfb);
    acc(IOP_OP_WRITE, 8'h14, 3'h0, 8'h00);
    acc(IOP_OP_WRITE, 8'h15, 3'h0, 8'h00);
    `CHK(hit_out, 1'b0)
    acc(IOP_OP_WRITE, 8'h16, 3'h0, 8'h5a);
    `CHK(res, 8'h0a)
    repeat (4) @(posedge mclk_in);
    `CHK({wide_oe, pc_out}, 12'h07a)
    e = 8'h0a;
    for (int i = 0; i < 8; i++) begin
      acc(i < 4 ? IOP_OP_SET : IOP_OP_CLR, 8'h16, 3'(i % 4), 8'h00);
      e = i < 4 ? e | (8'h01 << i) : e & ~(8'h01 << (i % 4));
      `CHK({res, pc_out}, {e, e[3:0]})
    end
    acc(IOP_OP_CPL, 8'h16, 3'h0, 8'h00);
    `CHK({res, pc_out}, 12'h0ff)
    acc(IOP_OP_CLR, 8'h12, 3'h3, 8'h00);
    `CHK(wide_oe, 8'h0f)
    wx_en <= 8'h40;
    acc(IOP_OP_CPLA, 8'h12, 3'h0, 8'h00);
    `CHK({res, wide_oe}, 16'h4c0f)
    acc(IOP_OP_SET, 8'h12, 3'h2, 8'h00);
    `CHK({res, wide_oe}, 16'hb74b)
    wx_en <= 8'h00;
    acc(IOP_OP_SET, 8'h12, 3'h6, 8'h00);
    acc(IOP_OP_SET, 8'h12, 3'h3, 8'h00);
    acc(IOP_OP_READ, 8'h12, 3'h0, 8'h00);
    `CHK(res, 8'hff)
    $display("t_write_bits finished");
  endtask
  task automatic t_wake(input logic [7:0] en, input int want);
    int n;
    n = 0;
    wx_en <= en;
    pb_val <= 8'h00;
    repeat (4) begin
      @(negedge mclk_in);
      if (wake_out !== 1'b0) n++;
    end
    `CHK(n, want)
    @(posedge mclk_in);
    wx_en <= 8'h00;
    pb_val <= 8'hff;
    repeat (2) @(posedge mclk_in);
    $display("t_wake finished");
  endtask
  task automatic t_buzz();
    int r0;
    int r1;
    logic p;
    r0 = -1;
    r1 = -1;
    acc(IOP_OP_WRITE, 8'h12, 3'h0, 8'hfc);
    `CHK({buzzer_active_out, wide_oe[1:0]}, 3'h7)
    p = wide_out[0];
    for (int c = 0; c < 40 && r1 < 0; c++) begin
      @(negedge mclk_in);
      if (wide_out[0] && !p) begin
        if (r0 < 0) r0 = c;
        else r1 = c;
      end
      p = wide_out[0];
    end
    if (r1 < 0) begin
      miscompares++;
      $display("BAD %0t buzzer tone never toggled", $time);
      test_done();
    end
    `CHK(r1 - r0, 4 << P_BZ_SEL)
    @(posedge mclk_in);
    acc(IOP_OP_SET, 8'h12, 3'h0, 8'h00);
    `CHK({buzzer_active_out, wide_out[1:0]}, 3'h0)
    $display("t_buzz finished");
  endtask
  initial begin
    repeat (6) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    t_reset();
    t_read();
    t_write_bits();
    t_wake(8'h40, 0);
    t_wake(8'h20, 1);
    t_wake(8'h04, 1);
    t_buzz();
    test_done();
  end
endmodule // test_io_ports_with_buzzer
`default_nettype wire
